// *** rtl/asp_pkg.sv ***
// Purpose: shared types and constants for the converter serial port
// Assumes: serial pins sampled by mclk through two flops
// Notes:   configuration byte is 8 bits, start bit is bit 7
package asp_pkg;
   localparam int          ASP_CFG_BITS   = 8;
   localparam int          ASP_START_POS  = 7;
   localparam int          ASP_RESULT_W   = 16;
   localparam logic [2:0]  ASP_CNT_RESET  = 3'h0;
   localparam logic [1:0]  ASP_SYNC_RESET = 2'h3;

   typedef enum {
      ASP_HUNT,
      ASP_CFG,
      ASP_WAIT,
      ASP_SHIFT
   } asp_state_t;

   // pins as seen from the host side
   typedef struct packed {
      logic csN;
      logic sclk;
      logic din;
   } asp_pins_t;

   // serial output pin, enable low while driving
   typedef struct packed {
      logic dout;
      logic doutOeN;
   } asp_dout_t;
endpackage : asp_pkg

// *** rtl/asp_serial_port.sv ***
// What this block does
// - capture input on shift clock rise, selected
// - next output bit on shift clock fall
// - deselected: clock and input ignored, frame back to hunt
// - deselected: serial output released, high impedance
// - internal clock: strobe rises when result ready
// - external clock mode: strobe held low
// - strobe always driven, never released
// - first one after select is config top
//
// Purpose: pin side of the converter serial port
// Assumes: pins asynchronous to mclk; sclk much slower than mclk
// Notes:   result word comes from the converter core
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port
   import asp_pkg::*;
#(
   parameter int RESULT_W = ASP_RESULT_W
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire asp_pins_t           pins,
   output var  asp_dout_t           doutPin,
   output logic                     resultReadyStrobe,
   input  wire logic                extClockMode,
   input  wire logic                resultValid,
   input  wire logic [RESULT_W-1:0] resultWord,
   output logic                     cfgValid,
   output logic [ASP_CFG_BITS-1:0]  cfgByte
);

   localparam int         SYNC_N       = 3;
   localparam int         SYNC_CS      = 2;
   localparam int         SYNC_CK      = 1;
   localparam int         SYNC_DI      = 0;
   localparam logic [2:0] CFG_LAST_CNT = 3'(ASP_CFG_BITS - 2);

   logic [SYNC_N-1:0]       pinRaw;
   logic [SYNC_N-1:0]       pinSync;
   logic                    sclkPrev;
   asp_state_t              state;
   asp_state_t              next_state;
   logic [2:0]              cfgCnt;
   logic [ASP_CFG_BITS-1:0] cfgShift;
   logic [RESULT_W-1:0]     outShift;
   logic                    resultPending;
   logic                    doutReg;
   logic                    doutOeNReg;

   assign pinRaw[SYNC_CS] = pins.csN;
   assign pinRaw[SYNC_CK] = pins.sclk;
   assign pinRaw[SYNC_DI] = pins.din;

   // two flops per pin
   for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
      logic [1:0] stage;
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            stage <= (g == SYNC_CS) ? ASP_SYNC_RESET : 2'h0;
         end else begin
            stage <= {stage[0], pinRaw[g]};
         end
      end
      assign pinSync[g] = stage[1];
   end

   // previous shift clock level
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclkPrev <= 1'b0;
      end else begin
         sclkPrev <= pinSync[SYNC_CK];
      end
   end

   // edge detect on synced pins
   wire csLow    = ~pinSync[SYNC_CS];
   wire sclkRise = csLow & pinSync[SYNC_CK] & ~sclkPrev;
   wire sclkFall = csLow & ~pinSync[SYNC_CK] & sclkPrev;
   wire dinBit   = pinSync[SYNC_DI];

   // frame decode
   wire cfgStart     = (state == ASP_HUNT) & sclkRise & dinBit;
   wire cfgStep      = (state == ASP_CFG) & sclkRise;
   wire cfgLast      = cfgStep & (cfgCnt == CFG_LAST_CNT);
   wire loadResult   = resultValid & ((state == ASP_WAIT) | cfgLast);
   wire shiftOut     = (state == ASP_SHIFT) & sclkFall;
   wire next_strobe  = ~extClockMode & (resultPending | (resultValid & (state == ASP_WAIT)));
   wire next_doutOeN = ~csLow;
   wire next_dout    = csLow & (state == ASP_SHIFT) & outShift[RESULT_W-1];
   wire [ASP_CFG_BITS-1:0] next_cfg = {cfgShift[ASP_CFG_BITS-2:0], dinBit};

   always_comb begin
      next_state = state;
      case (state)
         ASP_HUNT: begin
            if (sclkRise && dinBit) begin
               next_state = ASP_CFG;
            end
         end
         ASP_CFG: begin
            if (cfgLast) begin
               next_state = (extClockMode || resultValid) ? ASP_SHIFT : ASP_WAIT;
            end
         end
         ASP_WAIT: begin
            if (resultValid) begin
               next_state = ASP_SHIFT;
            end
         end
         ASP_SHIFT: begin
            next_state = ASP_SHIFT;
         end
         default: begin
            next_state = ASP_HUNT;
         end
      endcase
      if (!csLow) begin
         next_state = ASP_HUNT;
      end
   end

   // next state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ASP_HUNT;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfgCnt <= ASP_CNT_RESET;
      end else if (cfgStart) begin
         cfgCnt <= ASP_CNT_RESET;
      end else if (cfgStep) begin
         cfgCnt <= cfgCnt + 3'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfgShift <= '0;
      end else if (cfgStart) begin
         cfgShift <= {{(ASP_CFG_BITS-1){1'b0}}, 1'b1};
      end else if (cfgStep) begin
         cfgShift <= next_cfg;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfgValid <= 1'b0;
      end else begin
         cfgValid <= cfgLast;
      end
   end

   // last full byte
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfgByte <= '0;
      end else if (cfgLast) begin
         cfgByte <= next_cfg;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         outShift <= '0;
      end else if (loadResult) begin
         outShift <= resultWord;
      end else if (shiftOut) begin
         outShift <= {outShift[RESULT_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resultPending <= 1'b0;
      end else if (loadResult) begin
         resultPending <= ~extClockMode;
      end else if (shiftOut || !csLow) begin
         resultPending <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         doutOeNReg <= 1'b1;
      end else begin
         doutOeNReg <= next_doutOeN;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         doutReg <= 1'b0;
      end else begin
         doutReg <= next_dout;
      end
   end

   assign doutPin = '{dout: doutReg, doutOeN: doutOeNReg};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resultReadyStrobe <= 1'b0;
      end else begin
         resultReadyStrobe <= next_strobe;
      end
   end

endmodule : asp_serial_port
`default_nettype wire

// *** verif/asp_props.sv ***
// Purpose: port checks
// Assumes: bound to asp_serial_port
// Notes:   pins seen 3 mclk late
`timescale 1ns/1ps
`default_nettype none
module asp_props
   import asp_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire asp_pins_t  pins,
   input wire asp_dout_t  doutPin,
   input wire logic       resultReadyStrobe,
   input wire logic       extClockMode,
   input wire logic       resultValid,
   input wire logic       cfgValid,
   input wire logic [7:0] cfgByte
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_oe; pins.csN [*5] |-> doutPin.doutOeN; endproperty
   a_oe: assert property (p_oe) else $error("oe idle");
   property p_do; pins.csN [*5] |-> !doutPin.dout; endproperty
   a_do: assert property (p_do) else $error("dout idle");
   property p_cf; pins.csN [*5] |-> !cfgValid; endproperty
   a_cf: assert property (p_cf) else $error("cfg idle");
   property p_sel; cfgValid |-> !$past(pins.csN, 4); endproperty
   a_sel: assert property (p_sel) else $error("cfg unselected");
   property p_st; cfgValid |-> cfgByte[ASP_START_POS]; endproperty
   a_st: assert property (p_st) else $error("start bit");
   property p_ex; extClockMode [*3] |-> !resultReadyStrobe; endproperty
   a_ex: assert property (p_ex) else $error("strobe ext");
   property p_sr; $rose(resultReadyStrobe) |->
      ($past(resultValid) || $past(resultValid, 2)) && !$past(extClockMode);
   endproperty
   a_sr: assert property (p_sr) else $error("strobe cause");
   property p_hd; (!pins.csN && pins.sclk) [*8] |-> $stable(doutPin.dout); endproperty
   a_hd: assert property (p_hd) else $error("dout moved");
   cover property (cfgValid);
   cover property ($rose(resultReadyStrobe));
   cover property ($fell(doutPin.doutOeN));
endmodule : asp_props
bind asp_serial_port asp_props u_props (.mclk, .rst_n, .pins, .doutPin,
   .resultReadyStrobe, .extClockMode, .resultValid, .cfgValid, .cfgByte);
`default_nettype wire

// *** verif/asp_host.sv ***
// Purpose: host driving the serial pins
// Assumes: drives on mclk falls
// Notes:   link half period 4 mclk
`timescale 1ns/1ps
`default_nettype none
module asp_host
   import asp_pkg::*;
(
   input  wire logic      mclk,
   input  wire logic      strobe,
   input  wire asp_dout_t dp,
   output var  asp_pins_t pins
);
   // released line reads inverted
   wire logic doutLine = dp.doutOeN ? ~dp.dout : dp.dout;
   initial pins = 3'h4;
   task automatic hw(input int n);
      repeat (n) @(negedge mclk);
   endtask : hw
   task automatic frame(input logic [9:0] b, output logic [15:0] rx);
      pins.csN = 1'b0;
      for (int i = 9; i >= 0; i--) begin
         pins.sclk = 1'b0;
         pins.din = b[i];
         hw(4);
         pins.sclk = 1'b1;
         hw(4);
      end
      for (int k = 0; k < 99 && !strobe; k++) hw(1);
      hw(4);
      rx[15] = doutLine;
      for (int j = 14; j >= 0; j--) begin
         pins.sclk = 1'b0;
         hw(4);
         pins.sclk = 1'b1;
         hw(4);
         rx[j] = doutLine;
      end
      pins.csN = 1'b1;
      for (int i = 0; i < 20; i++) begin
         pins.sclk = ~pins.sclk;
         pins.din = ~pins.din;
         hw(2);
      end
   endtask : frame
endmodule : asp_host
`default_nettype wire

// *** verif/adc_serial_port_pins_tb.sv ***
// Purpose: bench for the serial port
// Assumes: host model drives the pins
// Notes:   checks after each frame
`timescale 1ns/1ps
`default_nettype none
module adc_serial_port_pins_tb
   import asp_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        extClockMode = 1'b1;
   logic        resultValid = 1'b0;
   logic [15:0] resultWord = 16'ha5c3;
   logic [15:0] rx;
   logic [7:0]  cfgByte;
   logic        resultReadyStrobe;
   asp_pins_t   pins;
   asp_dout_t   doutPin;
   int          mismatches = 0;
   int          n_compared = 0;
   initial forever #20 mclk = ~mclk;
   asp_serial_port dut (.mclk, .rst_n, .pins, .doutPin, .resultReadyStrobe, .extClockMode,
      .resultValid, .resultWord, .cfgValid(), .cfgByte);
   asp_host host (.mclk, .strobe(resultReadyStrobe), .dp(doutPin), .pins);
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic summarize;
      if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task automatic t_ext;
      resultValid = 1'b1;
      host.frame(10'h09b, rx);
      resultValid = 1'b0;
      chk("rx", 16'ha5c3, rx);
      chk("cfgByte", 16'h009b, 16'(cfgByte));
      chk("doutOeN", 16'h0001, 16'(doutPin.doutOeN));
   endtask : t_ext
   task automatic t_int;
      extClockMode = 1'b0;
      resultWord = 16'h3c5a;
      resultValid = 1'b1;
      host.frame(10'h0c6, rx);
      resultValid = 1'b0;
      chk("rx", 16'h3c5a, rx);
      chk("cfgByte", 16'h00c6, 16'(cfgByte));
      chk("strobe", 16'h0000, 16'(resultReadyStrobe));
   endtask : t_int
   initial begin
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      t_ext();
      t_int();
      summarize();
   end
   initial begin
      #100us;
      mismatches++;
      summarize();
   end
endmodule : adc_serial_port_pins_tb
`default_nettype wire
